// ---- verilog/wcfg_pkg.sv ----
// package for the write-once configuration option block
// assumes an 8-bit register port with byte addresses in the device map
package wcfg_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam logic [15:0] CFG2_ADDR = 16'h001E;
	localparam logic [15:0] CFG1_ADDR = 16'h001F;
	localparam logic [7:0] CFG1_RESET = 8'h00;
	localparam logic [7:0] CFG2_RESET = 8'h00;
	// option register 1 fields
	localparam int unsigned C1_STOP_EN = 1;
	localparam int unsigned C1_SHORT_STOP_RECOVERY = 2;
	localparam int unsigned C1_VMON_LVL = 3;
	localparam int unsigned C1_WD_RATE = 6;
	// option register 2 fields
	localparam int unsigned C2_XTAL_EN = 5;
	localparam int unsigned C2_EXTCLK_EN = 6;
	localparam int unsigned C2_BAUD_SRC = 0;
	// cycle counts in crystal clock cycles
	localparam logic [17:0] STOP_REC_SHORT = 18'h0_0020;
	localparam logic [17:0] STOP_REC_LONG = 18'h0_1000;
	localparam logic [17:0] WD_SHORT = 18'h0_1FF0;
	localparam logic [17:0] WD_LONG = 18'h3_FFF0;
	localparam logic [17:0] STAB_XTAL = 18'h0_1000;
	localparam logic [17:0] STAB_EXT = 18'h0_0010;
	typedef enum logic [1:0] {
		WCFG_PIN_GPIO = 2'b00,
		WCFG_PIN_CLKIN = 2'b01,
		WCFG_PIN_XTAL = 2'b10
	} wcfg_pin_mode_t;
	typedef enum logic [1:0] {
		WCFG_MON_EXT = 2'b00,
		WCFG_MON_XTAL_SLOW = 2'b01,
		WCFG_MON_XTAL_FAST = 2'b10
	} wcfg_mon_range_t;
endpackage : wcfg_pkg

// ---- verilog/wcfg_once_reg.sv ----
// one write-once option register with power-on-only bits
// assumes por_rst is asserted whenever sys_rst comes from power-on
`timescale 1ns/1ps
module wcfg_once_reg #(
	parameter int unsigned WIDTH = 8,
	parameter logic [7:0] POR_ONLY = 8'h00
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] value,
	output logic written
);
	typedef struct packed {
		logic [WIDTH-1:0] val;
		logic done;
	} wcfg_reg_st_t;
	wcfg_reg_st_t st_q;
	wcfg_reg_st_t st_d;
	logic [WIDTH-1:0] keep_q;

	always_comb
	begin
		st_d = st_q;
		if (wr_en && !st_q.done) // [R01] [R18]
		begin
			st_d.val = wr_data;
			st_d.done = 1'b1;
		end
	end

	// power-on-only bits live apart so other resets leave them alone
	always_ff @(posedge clk or posedge por_rst)
	begin
		if (por_rst)
			keep_q <= '0; // [R03]
		else if (wr_en && !st_q.done && !sys_rst)
			keep_q <= wr_data & POR_ONLY[WIDTH-1:0];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_q <= '0; // [R02]
		else
			st_q <= st_d;
	end

	assign value = (st_q.val & ~POR_ONLY[WIDTH-1:0]) | (keep_q & POR_ONLY[WIDTH-1:0]);
	assign written = st_q.done;
endmodule : wcfg_once_reg

// ---- verilog/wcfg_decode.sv ----
// decode of option bits into clock, pin and timing selections
// assumes the option bits are stable register outputs
`timescale 1ns/1ps
module wcfg_decode (
	input wire logic crystal_enable,
	input wire logic external_clock_enable,
	input wire logic short_stop_recovery,
	input wire logic watchdog_rate_select,
	input wire logic slow_crystal,
	output wcfg_pkg::wcfg_pin_mode_t pin_mode,
	output wcfg_pkg::wcfg_mon_range_t mon_range,
	output logic [17:0] stab_cycles,
	output logic [17:0] stop_rec_cycles,
	output logic [17:0] watchdog_cycles
);
	import wcfg_pkg::*;
	logic xtal_eff;

	assign xtal_eff = crystal_enable && external_clock_enable; // [R09]

	always_comb
	begin
		if (!external_clock_enable)
			pin_mode = WCFG_PIN_GPIO; // [R10]
		else if (xtal_eff)
			pin_mode = WCFG_PIN_XTAL;
		else
			pin_mode = WCFG_PIN_CLKIN;
	end

	always_comb
	begin
		if (!crystal_enable)
			mon_range = WCFG_MON_EXT; // [R11]
		else if (slow_crystal)
			mon_range = WCFG_MON_XTAL_SLOW;
		else
			mon_range = WCFG_MON_XTAL_FAST;
	end

	assign stab_cycles = crystal_enable ? STAB_XTAL : STAB_EXT; // [R12]
	assign stop_rec_cycles = short_stop_recovery ? STOP_REC_SHORT : STOP_REC_LONG; // [R13] [R15]
	assign watchdog_cycles = watchdog_rate_select ? WD_SHORT : WD_LONG; // [R14] [R16]
endmodule : wcfg_decode

// ---- verilog/wcfg_top.sv ----
// write-once configuration option registers with decoded option outputs
// assumes a one-cycle strobe register port; por_rst accompanies sys_rst at power-on
//
// Summary of operation
// R01 - one write per register after each reset
// R02 - reset clears all option bits; sys_rst without por_rst keeps the voltage level bit
// R03 - voltage level bit cleared by power-on only
// R04 - registers decoded at 001E and 001F
// R05 - reads return contents at any time
// R06 - software writes options first after reset
// R07 - mask variant ignores configuration writes
// R08 - baud source: 1 bus clock, 0 crystal
// R09 - crystal enable needs external clock enable; only pin_mode applies it, stab_cycles and mon_range use crystal enable alone
// R10 - enables select gpio, clock input, crystal
// R11 - crystal enable selects monitor frequency range
// R12 - stabilization 4096 cycles crystal, 16 otherwise
// R13 - stop recovery short or long option
// R14 - watchdog timeout long or short option
// R15 - short recovery 32 cycles, else 4096
// R16 - watchdog 8176 when set, else 262128
// R17 - stop instruction allowed when bit set
// R18 - later writes ignored silently until reset
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module wcfg_top #(
	parameter bit MASK_ROM = 1'b0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	output logic [7:0] config_option_reg_1,
	output logic [7:0] config_option_reg_2,
	output logic config_1_written,
	output logic config_2_written,
	output logic serial_baud_clock_source,
	output logic stop_enable,
	output wcfg_pkg::wcfg_pin_mode_t pin_mode,
	output wcfg_pkg::wcfg_mon_range_t mon_range,
	output logic [17:0] stab_cycles,
	output logic [17:0] stop_rec_cycles,
	output logic [17:0] watchdog_cycles
);
	import wcfg_pkg::*;
	typedef struct packed {
		logic [7:0] rdata;
	} wcfg_top_st_t;
	wcfg_top_st_t st_q;
	wcfg_top_st_t st_d;
	logic wr1;
	logic wr2;
	logic [7:0] c1;
	logic [7:0] c2;

	// write decode, blocked entirely on mask variants
	assign wr1 = wr_stb && (addr == CFG1_ADDR) && !MASK_ROM; // [R04] [R07]
	assign wr2 = wr_stb && (addr == CFG2_ADDR) && !MASK_ROM; // [R04] [R07]

	wcfg_once_reg #(
		.WIDTH(8),
		.POR_ONLY(8'h08)
	) u_cfg1 (
		.clk(clk),
		.sys_rst(sys_rst),
		.por_rst(por_rst),
		.wr_en(wr1),
		.wr_data(wdata),
		.value(c1),
		.written(config_1_written)
	);

	wcfg_once_reg #(
		.WIDTH(8),
		.POR_ONLY(8'h00)
	) u_cfg2 (
		.clk(clk),
		.sys_rst(sys_rst),
		.por_rst(por_rst),
		.wr_en(wr2),
		.wr_data(wdata),
		.value(c2),
		.written(config_2_written)
	);

	always_comb
	begin
		st_d = st_q;
		st_d.rdata = 8'h00;
		if (rd_stb)
		begin
			unique case (addr)
				CFG1_ADDR: st_d.rdata = c1; // [R05]
				CFG2_ADDR: st_d.rdata = c2; // [R05]
				default: st_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign rdata = st_q.rdata;
	assign config_option_reg_1 = c1;
	assign config_option_reg_2 = c2;
	assign serial_baud_clock_source = c2[C2_BAUD_SRC]; // [R08]
	assign stop_enable = c1[C1_STOP_EN]; // [R17]

	wcfg_decode u_dec (
		.crystal_enable(c2[C2_XTAL_EN]),
		.external_clock_enable(c2[C2_EXTCLK_EN]),
		.short_stop_recovery(c1[C1_SHORT_STOP_RECOVERY]),
		.watchdog_rate_select(c1[C1_WD_RATE]),
		.slow_crystal(c2[4]),
		.pin_mode(pin_mode),
		.mon_range(mon_range),
		.stab_cycles(stab_cycles),
		.stop_rec_cycles(stop_rec_cycles),
		.watchdog_cycles(watchdog_cycles)
	);
endmodule : wcfg_top

// ---- verification/wcfg_chk.sv ----
// checker for the option registers
// assumes binding to wcfg_top
`timescale 1ns/1ps
module wcfg_chk #(
	parameter bit MASK_ROM = 1'b0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rdata,
	input wire logic [7:0] config_option_reg_1,
	input wire logic [7:0] config_option_reg_2,
	input wire logic config_1_written,
	input wire logic serial_baud_clock_source,
	input wire wcfg_pkg::wcfg_pin_mode_t pin_mode,
	input wire logic [17:0] stab_cycles,
	input wire logic [17:0] stop_rec_cycles,
	input wire logic [17:0] watchdog_cycles
);
	import wcfg_pkg::*;
	wire logic [7:0] c2 = config_option_reg_2;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_wr_first: assert property (wr_stb && addr == CFG1_ADDR && !config_1_written
		|=> config_option_reg_1 == (MASK_ROM ? $past(config_option_reg_1) : $past(wdata))
		&& config_1_written == !MASK_ROM) else $error("write lost");
	a_wr_ignore: assert property (config_1_written |=> $stable(config_option_reg_1))
		else $error("rewrite");
	a_rd_back: assert property (rd_stb && addr == CFG2_ADDR |=> rdata == c2)
		else $error("read");
	a_rd_quiet: assert property (!rd_stb |=> rdata == 8'h00) else $error("rdata");
	a_baud_src: assert property (serial_baud_clock_source == c2[0]) else $error("baud");
	a_pin_sel: assert property (pin_mode == (!c2[6] ? WCFG_PIN_GPIO : c2[5] ? WCFG_PIN_XTAL : WCFG_PIN_CLKIN))
		else $error("pins");
	a_stab_len: assert property (stab_cycles == (c2[5] ? STAB_XTAL : STAB_EXT)) else $error("stab");
	a_stop_rec: assert property (stop_rec_cycles == (config_option_reg_1[2] ? STOP_REC_SHORT : STOP_REC_LONG))
		else $error("stop");
	a_wd_rate: assert property (watchdog_cycles == (config_option_reg_1[6] ? WD_SHORT : WD_LONG))
		else $error("wdog");
endmodule : wcfg_chk
bind wcfg_top wcfg_chk #(.MASK_ROM(MASK_ROM)) u_chk (.clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
	.config_option_reg_1, .config_option_reg_2, .config_1_written, .serial_baud_clock_source, .pin_mode,
	.stab_cycles, .stop_rec_cycles, .watchdog_cycles);

// ---- verification/test_write_once_config_options.sv ----
// bench for the option registers
// assumes a normal and a mask-variant instance on the same bus
`timescale 1ns/1ps
module test_write_once_config_options;
	import wcfg_pkg::*;
	logic clk = 0, sys_rst = 1, por_rst = 1, wr_stb = 0, rd_stb = 0, w1, w2, bd, stp, qw1, qw2;
	logic [15:0] addr = 0;
	logic [7:0] wdata = 0, rdata, r1, r2, q1, q2;
	logic [17:0] st, sr, wd;
	wcfg_pin_mode_t pm;
	wcfg_mon_range_t mr;
	logic [15:0] rows [4] = '{16'h4460, 16'h0020, 16'h0671, 16'hFF40};
	int bad_count = 0, total_checks = 0;
	wcfg_top dut (.clk, .sys_rst, .por_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .config_option_reg_1(r1),
		.config_option_reg_2(r2), .config_1_written(w1), .config_2_written(w2), .serial_baud_clock_source(bd),
		.stop_enable(stp), .pin_mode(pm), .mon_range(mr), .stab_cycles(st), .stop_rec_cycles(sr),
		.watchdog_cycles(wd));
	wcfg_top #(.MASK_ROM(1'b1)) dut_rom (.clk, .sys_rst, .por_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata(),
		.config_option_reg_1(q1), .config_option_reg_2(q2), .config_1_written(qw1), .config_2_written(qw2),
		.serial_baud_clock_source(), .stop_enable(), .pin_mode(), .mon_range(), .stab_cycles(),
		.stop_rec_cycles(), .watchdog_cycles());
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_stb <= w;
		rd_stb <= r;
		addr <= a;
		wdata <= d;
	endtask : bus
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus(0, 1, a, 8'h00);
		bus(0, 0, a, 8'h00);
		#1 chk(18'(rdata), 18'(e));
	endtask : rd
	task automatic rst(input logic p, input int n);
		@(posedge clk);
		sys_rst <= 1'b1;
		por_rst <= p;
		repeat (n) @(posedge clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
	endtask : rst
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#20000;
		bad_count++;
		tally_and_finish();
	end
	initial
	begin
		rst(1'b1, 16);
		#1 chk(18'({r1, r2}), 18'h0);
		chk(18'({w1, w2, pm, rdata}), 18'h0);
		chk(st, 18'd16);
		chk(sr, 18'd4096);
		chk(wd, 18'd262128);
		foreach (rows[i])
		begin
			rst(1'b1, 2);
			bus(1, 0, CFG1_ADDR, rows[i][15:8]);
			bus(1, 0, CFG2_ADDR, rows[i][7:0]);
			rd(CFG1_ADDR, rows[i][15:8]);
			rd(CFG2_ADDR, rows[i][7:0]);
			chk(18'({w1, w2}), 18'h3);
			chk(18'({q1, q2, qw1, qw2}), 18'h0);
			chk(18'(bd), 18'(rows[i][0]));
			chk(18'(stp), 18'(rows[i][9]));
			chk(sr, rows[i][10] ? 18'd32 : 18'd4096);
			chk(wd, rows[i][14] ? 18'd8176 : 18'd262128);
			chk(st, rows[i][5] ? 18'd4096 : 18'd16);
			chk(18'(pm), !rows[i][6] ? 18'd0 : rows[i][5] ? 18'd2 : 18'd1);
			chk(18'(mr), !rows[i][5] ? 18'd0 : rows[i][4] ? 18'd1 : 18'd2);
		end
		bus(1, 0, CFG1_ADDR, 8'h00);
		bus(1, 0, CFG2_ADDR, 8'hFF);
		rd(CFG1_ADDR, 8'hFF);
		rd(CFG2_ADDR, 8'h40);
		rd(16'h001D, 8'h00);
		rst(1'b0, 2);
		#1 chk(18'({r1, r2}), 18'h0800);
		chk(18'({w1, w2}), 18'h0);
		bus(1, 0, CFG1_ADDR, 8'h10);
		rd(CFG1_ADDR, 8'h10);
		rst(1'b1, 2);
		#1 chk(18'(r1), 18'h0);
		tally_and_finish();
	end
endmodule : test_write_once_config_options
